//--- bench/smc_config_regs_bench.sv
// Purpose: self-checking bench for the configuration register bank
// Assumes: AXI4-Lite master tasks; byte address is four times the register index
// Notes: plain register rows in a table, windows, pins and rate cases by hand
`timescale 1ns/1ps
`default_nettype none
module smc_config_regs_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, master_select = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, clock_select_field = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, shared_pin_in = 2'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic per_wr_stb, per_rd_stb, iic_scl_in, iic_sda_in, rate_tick;
  logic [9:0] per_wr_index, per_rd_index;
  logic [7:0] per_wdata, per_rdata = 8'h5A;
  smc_pkg::smc_cfg_type cfg;
  smc_pkg::smc_pins_type ssu_pins = 4'h9, iic_pins = 4'h6, shared_pins;
  logic [39:0] port_pin_in = 40'hAAAAAAAAAA, port_latch = 40'h5555555555;
  logic [39:0] port_direction_register = 40'hFFFFF00000, port_read_value;
  int fails = 0, check_count = 0, n, p0, p1, p2, wr_seen = 0, rd_seen = 0;
  logic [17:0] wr_last = 18'h0;
  // addr, write byte, read-back byte, response
  logic [29:0] rows [8] = '{{12'h020, 8'hFF, 8'h38, 2'h0}, {12'h020, 8'h00, 8'h00, 2'h0},
    {12'h630, 8'hFF, 8'h01, 2'h0}, {12'h630, 8'h00, 8'h00, 2'h0}, {12'h63C, 8'h8F, 8'h88, 2'h0},
    {12'h63C, 8'h4F, 8'h48, 2'h0}, {12'h63C, 8'h00, 8'h00, 2'h0}, {12'h004, 8'hFF, 8'h00, 2'h3}};

  smc_config_regs smc_config_regs_inst (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .per_wr_stb, .per_wr_index, .per_wdata, .per_rd_stb, .per_rd_index,
    .per_rdata, .cfg, .ssu_pins, .iic_pins, .shared_pins, .shared_pin_in, .iic_scl_in, .iic_sda_in,
    .clock_select_field, .master_select, .rate_tick, .port_pin_in, .port_latch, .port_direction_register,
    .port_read_value);

  always #5 clk_sys = ~clk_sys;

  // window strobes as the peripheral side sees them
  always @(posedge clk_sys) begin
    if (per_wr_stb) begin
      wr_seen <= wr_seen + 1;
      wr_last <= {per_wr_index, per_wdata};
    end
    if (per_rd_stb) begin
      rd_seen <= rd_seen + 1;
    end
  end

  task automatic end_sim;
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a stuck handshake ends the run instead of hanging it
  task automatic guard(inout int k);
    k++;
    if (k > 600) begin
      fails++;
      end_sim;
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task automatic wchk(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      guard(k);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // ready stays high, so back-to-back calls never drop and raise it in one step
    chk(s_axi_bresp, er);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      guard(k);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // skip two ticks so the measured gap is a whole period
  task automatic period(input logic [39:0] exp);
    int k, p;
    k = 0;
    p = 0;
    repeat (2) do begin
      @(posedge clk_sys);
      guard(k);
    end while (!rate_tick);
    do begin
      @(posedge clk_sys);
      p++;
    end while (!rate_tick && p < 300);
    chk(p, exp);
  endtask

  task automatic sda_lat(output int p);
    logic v;
    cyc(30);
    v = ~shared_pin_in[1];
    shared_pin_in <= {v, v};
    p = 0;
    do begin
      @(posedge clk_sys);
      p++;
    end while (iic_sda_in !== v && p < 100);
  endtask

  initial begin
    cyc(20);
    reset_n <= 1'b1;
    cyc(1);
    rchk(12'h020, 32'h0, 2'h0);
    rchk(12'h630, 32'h0, 2'h0);
    rchk(12'h63C, 32'h0, 2'h0);
    foreach (rows[i]) begin
      wchk(rows[i][29:18], rows[i][17:10], rows[i][1:0]);
      rchk(rows[i][29:18], {24'h0, rows[i][9:2]}, rows[i][1:0]);
    end
    s_axi_wstrb <= 4'h0;
    wchk(12'h630, 8'h01, 2'h0);
    s_axi_wstrb <= 4'hF;
    rchk(12'h630, 32'h0, 2'h0);
    rchk(12'h64C, 32'h5A, 2'h0);
    wchk(12'h020, 8'h38, 2'h0);
    chk(cfg, 40'h1C0);
    wchk(12'h674, 8'h11, 2'h2);
    rchk(12'h64C, 32'h0, 2'h2);
    rchk(12'h678, 32'h0, 2'h3);
    rchk(12'h480, 32'h0, 2'h2);
    wchk(12'h4CC, 8'h11, 2'h2);
    rchk(12'h47C, 32'h0, 2'h3);
    wchk(12'h020, 8'h10, 2'h0);
    rchk(12'h4CC, 32'h5A, 2'h0);
    rchk(12'h674, 32'h5A, 2'h0);
    wchk(12'h674, 8'h11, 2'h0);
    chk(wr_seen, 1);
    chk(wr_last, {10'h19D, 8'h11});
    chk(rd_seen, 3);
    cyc(2);
    chk(shared_pins, ssu_pins);
    wchk(12'h630, 8'h01, 2'h0);
    cyc(2);
    chk(shared_pins, iic_pins);
    chk(port_read_value, (port_direction_register & port_latch) | (~port_direction_register & port_pin_in));
    wchk(12'h63C, 8'h08, 2'h0);
    cyc(4);
    chk(port_read_value, {port_pin_in[39:35], port_latch[34], port_pin_in[33:0]});
    master_select <= 1'b1;
    period(28);
    clock_select_field <= 4'h8;
    wchk(12'h63C, 8'h10, 2'h0);
    period(28);
    wchk(12'h63C, 8'h20, 2'h0);
    period(112);
    master_select <= 1'b0;
    cyc(3);
    n = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (rate_tick !== 1'b0) n++;
    end
    chk(n, 0);
    wchk(12'h63C, 8'h00, 2'h0);
    sda_lat(p0);
    wchk(12'h63C, 8'h40, 2'h0);
    sda_lat(p1);
    wchk(12'h63C, 8'h80, 2'h0);
    sda_lat(p2);
    chk(p1 - p0, 8);
    chk(p2 - p0, 16);
    chk(cfg, 40'h0A2);
    chk(iic_scl_in, shared_pin_in[0]);
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(1);
    rchk(12'h63C, 32'h0, 2'h0);
    rchk(12'h020, 32'h0, 2'h0);
    rchk(12'h630, 32'h0, 2'h0);
    end_sim;
  end
endmodule
`default_nettype wire

//--- src/smc_config_regs.sv
// Purpose: standby, function switch and pin select registers on AXI4-Lite
// Assumes: one write and one read in flight; window regs live elsewhere
// Notes: window accesses are forwarded as one-cycle strobes
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_config_regs #(
  parameter int unsigned PORT_BITS = 40,
  parameter int unsigned SDA_DEPTH = 19
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        per_wr_stb,
  output logic [9:0]                  per_wr_index,
  output logic [7:0]                  per_wdata,
  output logic                        per_rd_stb,
  output logic [9:0]                  per_rd_index,
  input  wire logic [7:0]             per_rdata,
  output smc_pkg::smc_cfg_type        cfg,
  input  wire smc_pkg::smc_pins_type  ssu_pins,
  input  wire smc_pkg::smc_pins_type  iic_pins,
  output smc_pkg::smc_pins_type       shared_pins,
  input  wire logic [1:0]             shared_pin_in,
  output logic                        iic_scl_in,
  output logic                        iic_sda_in,
  input  wire logic [3:0]             clock_select_field,
  input  wire logic                   master_select,
  output logic                        rate_tick,
  input  wire logic [PORT_BITS-1:0]   port_pin_in,
  input  wire logic [PORT_BITS-1:0]   port_latch,
  input  wire logic [PORT_BITS-1:0]   port_direction_register,
  output logic [PORT_BITS-1:0]        port_read_value
);
  logic [7:0]           standby_q;
  logic [7:0]           switch_q;
  logic [7:0]           pinsel_q;
  logic                 aw_held_q;
  logic                 w_held_q;
  logic [9:0]           aw_idx_q;
  logic [7:0]           w_data_q;
  logic                 w_lane_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [1:0]           rresp_q;
  logic [7:0]           rdata_q;
  logic                 wr_go;
  logic                 ar_go;
  logic [9:0]           ar_idx;
  logic [7:0]           rd_byte;
  logic [1:0]           rd_resp;
  logic [1:0]           pin_meta_q;
  logic [1:0]           pin_sync_q;
  logic [PORT_BITS-1:0] port_meta_q;
  logic [PORT_BITS-1:0] port_sync_q;
  logic [PORT_BITS-1:0] excl_mask;
  logic [PORT_BITS-1:0] read_pin;

  function automatic logic in_ser(input logic [9:0] idx);
    return idx >= `SMC_SER_LO && idx <= `SMC_SER_HI;
  endfunction
  function automatic logic in_tmr(input logic [9:0] idx);
    return idx >= `SMC_TMR_LO && idx <= `SMC_TMR_HI;
  endfunction
  function automatic logic is_own(input logic [9:0] idx);
    return idx == `SMC_IDX_STANDBY || idx == `SMC_IDX_SWITCH || idx == `SMC_IDX_PINSEL;
  endfunction

  // configuration view of the registers
  assign cfg.serial_unit_standby      = standby_q[`SMC_B_SER];
  assign cfg.power_reduce_bit         = standby_q[`SMC_B_PWR];
  assign cfg.timer_unit_standby       = standby_q[`SMC_B_TMR];
  assign cfg.two_wire_function_switch = switch_q[`SMC_B_SEL];
  assign cfg.port_read_source_select  = pinsel_q[`SMC_B_IOIN];
  assign cfg.rate_double_select       = pinsel_q[`SMC_B_DBL];
  assign cfg.rate_half_select         = pinsel_q[`SMC_B_HALF];
  assign cfg.sda_delay_code           = pinsel_q[`SMC_B_DLY_HI:`SMC_B_DLY_LO];

  // a refused window access, blocked before the strobe is raised
  function automatic logic win_open(input logic [9:0] idx);
    return (in_ser(idx) && !standby_q[`SMC_B_SER]) || (in_tmr(idx) && !standby_q[`SMC_B_TMR]);
  endfunction
  function automatic logic [1:0] resp_of(input logic [9:0] idx);
    if (is_own(idx) || win_open(idx))
      return `SMC_RESP_OKAY;
    else if (in_ser(idx) || in_tmr(idx))
      return `SMC_RESP_SLVERR;
    else
      return `SMC_RESP_DECERR;
  endfunction

  // write channels, address and data taken in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_go         = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[11:2];
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SMC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= resp_of(aw_idx_q);
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // unassigned bits masked on write so they stay zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      standby_q <= `SMC_RST_REG;
      switch_q  <= `SMC_RST_REG;
      pinsel_q  <= `SMC_RST_REG;
    end else if (wr_go && w_lane_q) begin
      if (aw_idx_q == `SMC_IDX_STANDBY)
        standby_q <= w_data_q & `SMC_MASK_STBY;
      if (aw_idx_q == `SMC_IDX_SWITCH)
        switch_q <= w_data_q & `SMC_MASK_SW;
      if (aw_idx_q == `SMC_IDX_PINSEL)
        pinsel_q <= w_data_q & `SMC_MASK_PSEL;
    end
  end

  assign per_wr_stb   = wr_go && w_lane_q && win_open(aw_idx_q);
  assign per_wr_index = aw_idx_q;
  assign per_wdata    = w_data_q;

  // read channel, answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_q;
  assign ar_go         = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[11:2];
  assign per_rd_index  = ar_idx;
  assign per_rd_stb    = ar_go && win_open(ar_idx);

  always_comb begin
    rd_resp = resp_of(ar_idx);
    rd_byte = 8'h00;
    if (ar_idx == `SMC_IDX_STANDBY)
      rd_byte = standby_q;
    else if (ar_idx == `SMC_IDX_SWITCH)
      rd_byte = switch_q;
    else if (ar_idx == `SMC_IDX_PINSEL)
      rd_byte = pinsel_q;
    else if (win_open(ar_idx))
      rd_byte = per_rdata;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `SMC_RESP_OKAY;
      rdata_q  <= 8'h00;
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_resp;
      rdata_q  <= rd_byte;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = {24'h000000, rdata_q};

  // shared pins: standby releases them, switch picks the owner
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      shared_pins <= '0;
    else if (standby_q[`SMC_B_SER])
      shared_pins <= '0;
    else if (switch_q[`SMC_B_SEL])
      shared_pins <= iic_pins;
    else
      shared_pins <= ssu_pins;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
    end else begin
      pin_meta_q <= shared_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end
  assign iic_scl_in = pin_sync_q[0];

  smc_sda_delay #(
    .DEPTH (SDA_DEPTH)
  ) u_sda_delay (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .sda_in         (pin_sync_q[1]),
    .sda_delay_code (cfg.sda_delay_code),
    .sda_out        (iic_sda_in)
  );

  // slave mode takes its clock from the line, so no internal tick
  smc_rate_div u_rate_div (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .enable             (master_select && switch_q[`SMC_B_SEL] && !standby_q[`SMC_B_SER]),
    .clock_select_field (clock_select_field),
    .rate_double_select (cfg.rate_double_select),
    .rate_half_select   (cfg.rate_half_select),
    .tick               (rate_tick)
  );

  // port read path; pins cross from outside, so two flops first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_meta_q <= '0;
      port_sync_q <= '0;
    end else begin
      port_meta_q <= port_pin_in;
      port_sync_q <= port_meta_q;
    end
  end

  always_comb begin
    excl_mask = '0;
    excl_mask[`SMC_EXCL_BIT] = 1'b1;
  end
  // pin when input, or when select is set on a non-excluded bit
  assign read_pin = ~port_direction_register | ({PORT_BITS{pinsel_q[`SMC_B_IOIN]}} & ~excl_mask);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      port_read_value <= '0;
    else
      port_read_value <= (read_pin & port_sync_q) | (~read_pin & port_latch);
  end

  AST_SER_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ar_go && in_ser(ar_idx) && standby_q[`SMC_B_SER]
      |=> s_axi_rvalid && s_axi_rresp == `SMC_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("serial window read not refused in standby");
  AST_SER_NOSTB: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (per_wr_stb && in_ser(per_wr_index)) || (per_rd_stb && in_ser(per_rd_index)) |-> !cfg.serial_unit_standby)
    else $error("serial window strobe during standby");
  AST_TMR_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_go && in_tmr(aw_idx_q) && standby_q[`SMC_B_TMR]
      |-> !per_wr_stb ##1 s_axi_bvalid && s_axi_bresp == `SMC_RESP_SLVERR)
    else $error("timer window write not refused in standby");
  AST_ZERO_BITS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ((standby_q & ~`SMC_MASK_STBY) | (switch_q & ~`SMC_MASK_SW) | (pinsel_q & ~`SMC_MASK_PSEL)) == 8'h00
      and (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000))
    else $error("unassigned bits not zero");
  // sampled reset_n gates the next-cycle checks: flops are still in reset on the release edge
  AST_SWITCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n && !standby_q[`SMC_B_SER] && $stable(switch_q)
      |=> shared_pins == ($past(switch_q[`SMC_B_SEL]) ? $past(iic_pins) : $past(ssu_pins)))
    else $error("shared pins not routed to selected function");
  AST_SLAVE_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !master_select |=> !rate_tick)
    else $error("transfer tick in slave mode");
  AST_PORT_LATCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n && !pinsel_q[`SMC_B_IOIN] |=> (port_read_value & $past(port_direction_register))
      == ($past(port_latch) & $past(port_direction_register)))
    else $error("output bits not reading latch");
  AST_PORT_PIN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n && pinsel_q[`SMC_B_IOIN] |=> (port_read_value & ~excl_mask) == ($past(port_sync_q) & ~excl_mask))
    else $error("port bits not reading pin level");
  AST_PORT_EXCL: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n |=> port_read_value[`SMC_EXCL_BIT] == ($past(port_direction_register[`SMC_EXCL_BIT])
      ? $past(port_latch[`SMC_EXCL_BIT]) : $past(port_sync_q[`SMC_EXCL_BIT])))
    else $error("excluded port bit follows select");
endmodule
`default_nettype wire

//--- src/smc_params.svh
// Purpose: constants of the serial module configuration registers
// Assumes: register index = byte address / 4 on the AXI4-Lite slave
// Notes: field positions, masks, windows and delay counts live here
// How it works
// - While the serial standby bit is set, every access to the serial register window is refused.
// - While the timer standby bit is set, every access to the timer register window is refused.
// - Unassigned bits of the three registers always read back as zero.
// - The function switch bit gives the shared pins to the synchronous serial unit at 0, two-wire at 1.
// - The rate-double bit makes the two-wire transfer rate twice the clock-select rate.
// - The rate-half bit makes the two-wire transfer rate half the clock-select rate.
// - The delay code delays SDA by 3, 11 or 19 system clocks for codes 0, 1 and 2; code 3 can be written and also gives 19.
// - With port-read select at 0, input bits read the pin and output bits read the latch.
// - With port-read select at 1, every port bit except the excluded one reads the pin level.
// - One excluded port bit ignores the port-read select and follows its direction alone.
// - Rate modifiers act only on the master transfer clock; in slave mode no internal clock runs.
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_IDX_STANDBY 10'h008
`define SMC_IDX_SWITCH  10'h18C
`define SMC_IDX_PINSEL  10'h18F
`define SMC_SER_LO      10'h193
`define SMC_SER_HI      10'h19D
`define SMC_TMR_LO      10'h120
`define SMC_TMR_HI      10'h133
`define SMC_RST_REG     8'h00
`define SMC_MASK_STBY   8'h38
`define SMC_MASK_SW     8'h01
`define SMC_MASK_PSEL   8'hF8
`define SMC_B_SER       3
`define SMC_B_PWR       4
`define SMC_B_TMR       5
`define SMC_B_SEL       0
`define SMC_B_IOIN      3
`define SMC_B_DBL       4
`define SMC_B_HALF      5
`define SMC_B_DLY_LO    6
`define SMC_B_DLY_HI    7
`define SMC_DLY_C0      5'd3
`define SMC_DLY_C1      5'd11
`define SMC_DLY_C2      5'd19
`define SMC_EXCL_BIT    34
`define SMC_RESP_OKAY   2'h0
`define SMC_RESP_SLVERR 2'h2
`define SMC_RESP_DECERR 2'h3
// clock-select divisors, entry n at bits [9n+8:9n]
`define SMC_CKS_TABLE {9'h100, 9'h0E0, 9'h0C8, 9'h0A0, 9'h080, 9'h060, 9'h050, 9'h038, \
                       9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01C}
`endif

//--- src/smc_pkg.sv
// Purpose: types shared by the configuration register files
// Assumes: nothing
// Notes: constants are in smc_params.svh
package smc_pkg;
  typedef struct packed {
    logic       serial_unit_standby;
    logic       power_reduce_bit;
    logic       timer_unit_standby;
    logic       two_wire_function_switch;
    logic       port_read_source_select;
    logic       rate_double_select;
    logic       rate_half_select;
    logic [1:0] sda_delay_code;
  } smc_cfg_type;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } smc_pins_type;
endpackage

//--- src/smc_rate_div.sv
// Purpose: master transfer clock enable with double and half modifiers
// Assumes: clock-select and modifiers come from the system clock domain
// Notes: both modifiers set is not allowed; it then runs at the plain rate
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_rate_div (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic [3:0] clock_select_field,
  input  wire logic       rate_double_select,
  input  wire logic       rate_half_select,
  output logic            tick
);
  localparam logic [143:0] CKS_TABLE = `SMC_CKS_TABLE;
  logic [8:0]  base;
  logic [10:0] div_eff;
  logic [10:0] cnt_q;
  logic [10:0] gap_q;
  logic [5:0]  key_q;
  logic        seen_q;

  assign base = CKS_TABLE[clock_select_field*9 +: 9];
  always_comb begin
    div_eff = {2'h0, base};
    if (rate_double_select && !rate_half_select)
      div_eff = {3'h0, base[8:1]};
    else if (rate_half_select && !rate_double_select)
      div_eff = {1'h0, base, 1'b0};
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 11'h000;
      tick  <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 11'h000;
      tick  <= 1'b0;
    end else if (cnt_q >= div_eff - 11'h001) begin
      cnt_q <= 11'h000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      tick  <= 1'b0;
    end
  end

  // helper: cycles between ticks under unchanged settings
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q  <= 11'h000;
      key_q  <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      key_q  <= {clock_select_field, rate_double_select, rate_half_select};
      gap_q  <= tick ? 11'h000 : gap_q + 11'h001;
      if (!enable || key_q != {clock_select_field, rate_double_select, rate_half_select})
        seen_q <= 1'b0;
      else if (tick)
        seen_q <= 1'b1;
    end
  end

  AST_DOUBLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tick && seen_q && rate_double_select && !rate_half_select |-> gap_q == {3'h0, base[8:1]} - 11'h001)
    else $error("doubled rate tick spacing wrong");
  AST_HALF: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tick && seen_q && rate_half_select && !rate_double_select |-> gap_q == {1'h0, base, 1'b0} - 11'h001)
    else $error("halved rate tick spacing wrong");
endmodule
`default_nettype wire

//--- src/smc_sda_delay.sv
// Purpose: digital delay line for the two-wire data input
// Assumes: input already synchronised to clk_sys
// Notes: code 3 is not allowed and falls back to the longest tap
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_sda_delay #(
  parameter int unsigned DEPTH = 19
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       sda_in,
  input  wire logic [1:0] sda_delay_code,
  output logic            sda_out
);
  logic [DEPTH-1:0] shift_q;
  logic [4:0]       tap;
  logic [4:0]       warm_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      shift_q <= '1; // idle bus level
    else
      shift_q <= {shift_q[DEPTH-2:0], sda_in};
  end

  always_comb begin
    unique case (sda_delay_code)
      2'h0:    tap = `SMC_DLY_C0;
      2'h1:    tap = `SMC_DLY_C1;
      default: tap = `SMC_DLY_C2;
    endcase
  end
  assign sda_out = shift_q[tap - 5'd1];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      warm_q <= 5'h00;
    else if (warm_q != 5'h1F)
      warm_q <= warm_q + 5'h01;
  end

  AST_DLY3: assert property (@(posedge clk_sys) disable iff (!reset_n)
    warm_q > 5'd20 && sda_delay_code == 2'h0 |-> sda_out == $past(sda_in, 3))
    else $error("sda delay 3 wrong");
  AST_DLY11: assert property (@(posedge clk_sys) disable iff (!reset_n)
    warm_q > 5'd20 && sda_delay_code == 2'h1 |-> sda_out == $past(sda_in, 11))
    else $error("sda delay 11 wrong");
  AST_DLY19: assert property (@(posedge clk_sys) disable iff (!reset_n)
    warm_q > 5'd20 && sda_delay_code == 2'h2 |-> sda_out == $past(sda_in, 19))
    else $error("sda delay 19 wrong");
endmodule
`default_nettype wire
